/* common/slpm_consts.vh */
// Constants for the SONET line and section performance counters
`ifndef SLPM_CONSTS_VH
`define SLPM_CONSTS_VH
`define SLPM_ADDR_K_SECTION  8'h00
`define SLPM_ADDR_K_LINE     8'h04
`define SLPM_ADDR_K_FAR      8'h08
`define SLPM_ADDR_INT_STATUS 8'h0c
`define SLPM_ADDR_INT_CLEAR  8'h10
`define SLPM_ADDR_INT_ENABLE 8'h14
`define SLPM_ADDR_STATE      8'h18
`define SLPM_PAGE_CURRENT    2'b01
`define SLPM_PAGE_PREVIOUS   2'b10
`define SLPM_RST_K_SECTION   24'h000100
`define SLPM_RST_K_LINE      24'h000100
`define SLPM_RST_K_FAR       24'h000100
`define SLPM_RST_INT_ENABLE  6'h00
`define SLPM_UAS_SECONDS     4'ha
`define SLPM_B1_MAX          4'h8
`define SLPM_NUM_COUNTERS    14
`define SLPM_IX_CV_S         0
`define SLPM_IX_ES_S         1
`define SLPM_IX_SECTION_SEVERE_ERRORED_SECOND_COUNT        2
`define SLPM_IX_SEVERE_FRAME_SECOND_COUNT       3
`define SLPM_IX_CV_L         4
`define SLPM_IX_ES_L         5
`define SLPM_IX_LINE_SEVERE_ERRORED_SECOND_COUNT        6
`define SLPM_IX_LINE_UNAVAILABLE_SECOND_COUNT        7
`define SLPM_IX_FC_L         8
`define SLPM_IX_CV_F         9
`define SLPM_IX_ES_F         10
`define SLPM_IX_SES_F        11
`define SLPM_IX_UAS_F        12
`define SLPM_IX_FC_F         13
`define SLPM_INT_SECOND      0
`define SLPM_INT_PERIOD      1
`define SLPM_INT_UNAV_NEAR   2
`define SLPM_INT_UNAV_FAR    3
`define SLPM_INT_FAIL_NEAR   4
`define SLPM_INT_FAIL_FAR    5
`define SLPM_RESP_OKAY       2'b00
`define SLPM_RESP_SLVERR     2'b10
`endif

/* rtl/slpm_counters.v */
// Section and line performance counters with AXI4-Lite register access
`timescale 1ns/10ps
`default_nettype none
`include "slpm_consts.vh"
module slpm_counters #(
  parameter STS_N = 48
) (
  input  wire        I_CLOCK,
  input  wire        I_SRST,
  input  wire        I_FRAME,
  input  wire [3:0]  I_B1_ERRS,
  input  wire [9:0]  I_B2_ERRS,
  input  wire [7:0]  I_REI_ERRS,
  input  wire        I_SEF_DEFECT,
  input  wire        I_LOS_DEFECT,
  input  wire        I_AIS_DEFECT,
  input  wire        I_RDI_DEFECT,
  input  wire        I_AIS_FAIL,
  input  wire        I_LOWER_FAIL,
  input  wire        I_RFI_FAIL,
  input  wire        I_SEC_TICK,
  input  wire        I_PERIOD_TICK,
  input  wire [7:0]  I_AWADDR,
  input  wire        I_AWVALID,
  output reg         O_AWREADY,
  input  wire [31:0] I_WDATA,
  input  wire [3:0]  I_WSTRB,
  input  wire        I_WVALID,
  output reg         O_WREADY,
  output reg  [1:0]  O_BRESP,
  output reg         O_BVALID,
  input  wire        I_BREADY,
  input  wire [7:0]  I_ARADDR,
  input  wire        I_ARVALID,
  output reg         O_ARREADY,
  output reg  [31:0] O_RDATA,
  output reg  [1:0]  O_RRESP,
  output reg         O_RVALID,
  input  wire        I_RREADY,
  output reg         O_UNAVAIL_NEAR,
  output reg         O_UNAVAIL_FAR,
  output reg         O_IRQ
);
  localparam [31:0] B2_LIM  = 8 * STS_N;
  localparam [31:0] REI_LIM = (STS_N >= 48) ? 255 : 8 * STS_N;
  localparam [9:0]  B2_MAX  = B2_LIM[9:0];
  localparam [7:0]  REI_MAX = REI_LIM[7:0];
  localparam       NC      = `SLPM_NUM_COUNTERS;

  // Per-frame inputs clipped to what one frame can really carry
  wire [3:0]  b1_c  = (I_B1_ERRS > `SLPM_B1_MAX) ? `SLPM_B1_MAX : I_B1_ERRS;
  wire [9:0]  b2_c  = (I_B2_ERRS > B2_MAX) ? B2_MAX : I_B2_ERRS;
  wire [7:0]  rei_c = (I_REI_ERRS > REI_MAX) ? REI_MAX : I_REI_ERRS;

  reg  [23:0] acc_s;
  reg  [23:0] acc_l;
  reg  [23:0] acc_f;
  reg         seen_sef;
  reg         seen_los;
  reg         seen_ais;
  reg         seen_rdi;
  reg  [23:0] k_section;
  reg  [23:0] k_line;
  reg  [23:0] k_far;
  reg  [5:0]  int_status;
  reg  [5:0]  int_enable;
  reg         ais_fail_d;
  reg         rfi_fail_d;
  reg  [31:0] cur  [0:NC-1];
  reg  [31:0] prev [0:NC-1];

  // Totals of the closing second include the tick cycle itself
  wire [23:0] sum_s = acc_s + (I_FRAME ? {20'h00000, b1_c} : 24'h000000);
  wire [23:0] sum_l = acc_l + (I_FRAME ? {14'h0000, b2_c} : 24'h000000);
  wire [23:0] sum_f = acc_f + (I_FRAME ? {16'h0000, rei_c} : 24'h000000);
  wire        d_sef = seen_sef | I_SEF_DEFECT;
  wire        d_los = seen_los | I_LOS_DEFECT;
  wire        d_ais = seen_ais | I_AIS_DEFECT;
  wire        d_rdi = seen_rdi | I_RDI_DEFECT;
  wire        es_s  = (sum_s != 24'h000000) | d_sef | d_los;
  wire        section_severe_errored_second_count = (sum_s >= k_section) | d_sef | d_los;
  wire        es_l  = (sum_l != 24'h000000) | d_ais;
  wire        line_severe_errored_second_count = (sum_l >= k_line) | d_ais;
  wire        es_f  = (sum_f != 24'h000000) | d_rdi;
  wire        ses_f = (sum_f >= k_far) | d_rdi;
  wire        near_fail = I_AIS_FAIL | I_LOWER_FAIL;
  wire        fail_near_evt = near_fail & ~ais_fail_d;
  wire        fail_far_evt  = I_RFI_FAIL & ~rfi_fail_d;

  // Per-second accumulators, cleared at every tick
  always @(posedge I_CLOCK) begin
    if (I_SRST || I_SEC_TICK) begin
      acc_s    <= 24'h000000;
      acc_l    <= 24'h000000;
      acc_f    <= 24'h000000;
      seen_sef <= 1'b0;
      seen_los <= 1'b0;
      seen_ais <= 1'b0;
      seen_rdi <= 1'b0;
    end else begin
      acc_s    <= sum_s;
      acc_l    <= sum_l;
      acc_f    <= sum_f;
      seen_sef <= d_sef;
      seen_los <= d_los;
      seen_ais <= d_ais;
      seen_rdi <= d_rdi;
    end
  end

  // Failure edge trackers
  always @(posedge I_CLOCK) begin
    if (I_SRST) begin
      ais_fail_d <= 1'b0;
      rfi_fail_d <= 1'b0;
    end else begin
      ais_fail_d <= near_fail;
      rfi_fail_d <= I_RFI_FAIL;
    end
  end

  // Unavailability for near (0) and far (1) line
  wire [1:0] ses_vec = {ses_f, line_severe_errored_second_count};
  wire [1:0] unav;
  wire [1:0] unav_enter;
  wire [3:0] uas_add [0:1];
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_unav
      reg       state;
      reg [3:0] run;
      reg [3:0] next_run;
      reg       next_state;
      reg [3:0] add;
      always @* begin
        next_run   = run;
        next_state = state;
        add        = 4'h0;
        if (I_SEC_TICK) begin
          if (!state) begin
            next_run = ses_vec[g] ? run + 4'h1 : 4'h0;
            if (ses_vec[g] && run == `SLPM_UAS_SECONDS - 4'h1) begin
              next_state = 1'b1;
              next_run   = 4'h0;
              add        = `SLPM_UAS_SECONDS;
            end
          end else begin
            // Exit seconds still count as unavailable
            add      = 4'h1;
            next_run = ses_vec[g] ? 4'h0 : run + 4'h1;
            if (!ses_vec[g] && run == `SLPM_UAS_SECONDS - 4'h1) begin
              next_state = 1'b0;
              next_run   = 4'h0;
            end
          end
        end
      end
      always @(posedge I_CLOCK) begin
        if (I_SRST) begin
          state <= 1'b0;
          run   <= 4'h0;
        end else begin
          state <= next_state;
          run   <= next_run;
        end
      end
      assign unav[g]       = state;
      assign unav_enter[g] = next_state & ~state;
      assign uas_add[g]    = add;
    end
  endgenerate

  // Contributions per counter: per-second part and immediate event part
  reg [31:0] add_sec [0:NC-1];
  reg [31:0] add_evt [0:NC-1];
  integer j;
  always @* begin
    for (j = 0; j < NC; j = j + 1) begin
      add_sec[j] = 32'h00000000;
      add_evt[j] = 32'h00000000;
    end
    if (I_SEC_TICK) begin
      add_sec[`SLPM_IX_CV_S]   = {8'h00, sum_s};
      add_sec[`SLPM_IX_ES_S]   = {31'h0, es_s};
      add_sec[`SLPM_IX_SECTION_SEVERE_ERRORED_SECOND_COUNT]  = {31'h0, section_severe_errored_second_count};
      add_sec[`SLPM_IX_SEVERE_FRAME_SECOND_COUNT] = {31'h0, d_sef};
      add_sec[`SLPM_IX_CV_L]   = {8'h00, sum_l};
      add_sec[`SLPM_IX_ES_L]   = {31'h0, es_l};
      add_sec[`SLPM_IX_LINE_SEVERE_ERRORED_SECOND_COUNT]  = {31'h0, line_severe_errored_second_count};
      add_sec[`SLPM_IX_LINE_UNAVAILABLE_SECOND_COUNT]  = {28'h0, uas_add[0]};
      add_sec[`SLPM_IX_CV_F]   = {8'h00, sum_f};
      add_sec[`SLPM_IX_ES_F]   = {31'h0, es_f};
      add_sec[`SLPM_IX_SES_F]  = {31'h0, ses_f};
      add_sec[`SLPM_IX_UAS_F]  = {28'h0, uas_add[1]};
    end
    add_evt[`SLPM_IX_FC_L] = {31'h0, fail_near_evt};
    add_evt[`SLPM_IX_FC_F] = {31'h0, fail_far_evt};
  end

  // Period accumulation; a boundary snapshots into the previous bank
  integer i;
  always @(posedge I_CLOCK) begin
    for (i = 0; i < NC; i = i + 1) begin
      if (I_SRST) begin
        cur[i]  <= 32'h00000000;
        prev[i] <= 32'h00000000;
      end else if (I_PERIOD_TICK) begin
        prev[i] <= cur[i] + add_sec[i];
        // A failure starting on the boundary belongs to the new period
        cur[i]  <= add_evt[i];
      end else begin
        cur[i]  <= cur[i] + add_sec[i] + add_evt[i];
      end
    end
  end

  // AXI4-Lite write path; address and data are taken in either order
  reg  [7:0]  aw_addr;
  reg         aw_have;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  reg         w_have;
  wire        do_write = aw_have & w_have & ~O_BVALID;
  wire        wr_k_s   = do_write & (aw_addr == `SLPM_ADDR_K_SECTION);
  wire        wr_k_l   = do_write & (aw_addr == `SLPM_ADDR_K_LINE);
  wire        wr_k_f   = do_write & (aw_addr == `SLPM_ADDR_K_FAR);
  wire        wr_clr   = do_write & (aw_addr == `SLPM_ADDR_INT_CLEAR) & w_strb[0];
  wire        wr_en    = do_write & (aw_addr == `SLPM_ADDR_INT_ENABLE) & w_strb[0];
  wire        wr_ok    = wr_k_s | wr_k_l | wr_k_f | wr_en | wr_clr;
  wire [23:0] wmask    = {{8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

  always @(posedge I_CLOCK) begin
    if (I_SRST) begin
      O_AWREADY <= 1'b1;
      O_WREADY  <= 1'b1;
      O_BVALID  <= 1'b0;
      O_BRESP   <= `SLPM_RESP_OKAY;
      aw_have   <= 1'b0;
      w_have    <= 1'b0;
      aw_addr   <= 8'h00;
      w_data    <= 32'h00000000;
      w_strb    <= 4'h0;
    end else begin
      if (I_AWVALID && O_AWREADY) begin
        aw_addr   <= I_AWADDR;
        aw_have   <= 1'b1;
        O_AWREADY <= 1'b0;
      end
      if (I_WVALID && O_WREADY) begin
        w_data   <= I_WDATA;
        w_strb   <= I_WSTRB;
        w_have   <= 1'b1;
        O_WREADY <= 1'b0;
      end
      if (do_write) begin
        aw_have  <= 1'b0;
        w_have   <= 1'b0;
        O_BVALID <= 1'b1;
        O_BRESP  <= wr_ok ? `SLPM_RESP_OKAY : `SLPM_RESP_SLVERR;
      end
      if (O_BVALID && I_BREADY) begin
        O_BVALID  <= 1'b0;
        O_AWREADY <= 1'b1;
        O_WREADY  <= 1'b1;
      end
    end
  end

  // Thresholds and interrupt registers
  wire [5:0] int_set;
  assign int_set[`SLPM_INT_SECOND]    = I_SEC_TICK;
  assign int_set[`SLPM_INT_PERIOD]    = I_PERIOD_TICK;
  assign int_set[`SLPM_INT_UNAV_NEAR] = unav_enter[0];
  assign int_set[`SLPM_INT_UNAV_FAR]  = unav_enter[1];
  assign int_set[`SLPM_INT_FAIL_NEAR] = fail_near_evt;
  assign int_set[`SLPM_INT_FAIL_FAR]  = fail_far_evt;
  wire [5:0] int_clr = wr_clr ? w_data[5:0] : 6'h00;

  always @(posedge I_CLOCK) begin
    if (I_SRST) begin
      k_section  <= `SLPM_RST_K_SECTION;
      k_line     <= `SLPM_RST_K_LINE;
      k_far      <= `SLPM_RST_K_FAR;
      int_enable <= `SLPM_RST_INT_ENABLE;
      int_status <= 6'h00;
    end else begin
      if (wr_k_s) begin
        k_section <= (k_section & ~wmask) | (w_data[23:0] & wmask);
      end
      if (wr_k_l) begin
        k_line <= (k_line & ~wmask) | (w_data[23:0] & wmask);
      end
      if (wr_k_f) begin
        k_far <= (k_far & ~wmask) | (w_data[23:0] & wmask);
      end
      if (wr_en) begin
        int_enable <= w_data[5:0];
      end
      // Set beats clear so an event in the clear cycle survives
      int_status <= (int_status & ~int_clr) | int_set;
    end
  end

  // Read path; counters sit in two pages of sixteen words
  reg  [31:0] rd_word;
  reg         rd_ok;
  always @* begin
    rd_word = 32'h00000000;
    rd_ok   = 1'b1;
    if (I_ARADDR[7:6] == `SLPM_PAGE_CURRENT && I_ARADDR[5:2] < NC) begin
      rd_word = cur[I_ARADDR[5:2]];
    end else if (I_ARADDR[7:6] == `SLPM_PAGE_PREVIOUS && I_ARADDR[5:2] < NC) begin
      rd_word = prev[I_ARADDR[5:2]];
    end else begin
      case (I_ARADDR)
        `SLPM_ADDR_K_SECTION:  rd_word = {8'h00, k_section};
        `SLPM_ADDR_K_LINE:     rd_word = {8'h00, k_line};
        `SLPM_ADDR_K_FAR:      rd_word = {8'h00, k_far};
        `SLPM_ADDR_INT_STATUS: rd_word = {26'h0, int_status};
        `SLPM_ADDR_INT_CLEAR:  rd_word = 32'h00000000;
        `SLPM_ADDR_INT_ENABLE: rd_word = {26'h0, int_enable};
        `SLPM_ADDR_STATE:      rd_word = {30'h0, unav};
        default:               rd_ok   = 1'b0;
      endcase
    end
  end

  always @(posedge I_CLOCK) begin
    if (I_SRST) begin
      O_ARREADY <= 1'b1;
      O_RVALID  <= 1'b0;
      O_RDATA   <= 32'h00000000;
      O_RRESP   <= `SLPM_RESP_OKAY;
    end else if (I_ARVALID && O_ARREADY) begin
      O_ARREADY <= 1'b0;
      O_RVALID  <= 1'b1;
      O_RDATA   <= rd_word;
      O_RRESP   <= rd_ok ? `SLPM_RESP_OKAY : `SLPM_RESP_SLVERR;
    end else if (O_RVALID && I_RREADY) begin
      O_RVALID  <= 1'b0;
      O_ARREADY <= 1'b1;
    end
  end

  // Registered status pins
  always @(posedge I_CLOCK) begin
    if (I_SRST) begin
      O_UNAVAIL_NEAR <= 1'b0;
      O_UNAVAIL_FAR  <= 1'b0;
      O_IRQ          <= 1'b0;
    end else begin
      O_UNAVAIL_NEAR <= unav[0];
      O_UNAVAIL_FAR  <= unav[1];
      O_IRQ          <= |(int_status & int_enable);
    end
  end
endmodule
`default_nettype wire

/* test/slpm_counters_chk.sv */
// Port-level assertions for the performance counter block
`timescale 1ns/10ps
`default_nettype none
module slpm_counters_chk (
  input wire logic        I_CLOCK,
  input wire logic        I_SRST,
  input wire logic        I_SEC_TICK,
  input wire logic        I_AWVALID,
  input wire logic        O_AWREADY,
  input wire logic        I_WVALID,
  input wire logic        O_WREADY,
  input wire logic        O_BVALID,
  input wire logic        I_BREADY,
  input wire logic        I_ARVALID,
  input wire logic        O_ARREADY,
  input wire logic        O_RVALID,
  input wire logic        I_RREADY,
  input wire logic        O_UNAVAIL_NEAR,
  input wire logic        O_UNAVAIL_FAR,
  input wire logic        O_IRQ
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_SRST);
  logic [3:0] n_sec;
  // Saturates so a long run cannot wrap back below ten
  always @(posedge I_CLOCK) begin
    if (I_SRST) n_sec <= 4'h0;
    else if (I_SEC_TICK && n_sec != 4'hf) n_sec <= n_sec + 4'h1;
  end
  sequence s_wr_take;
    I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
  endsequence
  sequence s_rd_take;
    I_ARVALID && O_ARREADY;
  endsequence
  property p_wr_resp;
    s_wr_take |=> (!O_AWREADY && !O_WREADY) ##1 O_BVALID;
  endproperty
  property p_rd_resp;
    s_rd_take |=> O_RVALID && !O_ARREADY;
  endproperty
  property p_b_busy;
    O_BVALID |-> !O_AWREADY && !O_WREADY;
  endproperty
  property p_r_busy;
    O_RVALID |-> !O_ARREADY;
  endproperty
  property p_b_done;
    O_BVALID && I_BREADY |=> !O_BVALID && O_AWREADY && O_WREADY;
  endproperty
  property p_r_done;
    O_RVALID && I_RREADY |=> !O_RVALID && O_ARREADY;
  endproperty
  property p_rst;
    $fell(I_SRST) |-> O_AWREADY && O_ARREADY && !O_BVALID && !O_RVALID && !O_IRQ;
  endproperty
  property p_unav;
    (O_UNAVAIL_NEAR || O_UNAVAIL_FAR) |-> n_sec >= 4'ha;
  endproperty
  property p_unav_tick;
    $changed(O_UNAVAIL_NEAR) |-> $past(I_SEC_TICK) || $past(I_SEC_TICK, 2)
      || $past(I_SEC_TICK, 3);
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response late");
  a_rd_resp: assert property (p_rd_resp) else $error("read response late");
  a_b_busy: assert property (p_b_busy) else $error("write ready during response");
  a_r_busy: assert property (p_r_busy) else $error("read ready during response");
  a_b_done: assert property (p_b_done) else $error("write response not retired");
  a_r_done: assert property (p_r_done) else $error("read response not retired");
  a_rst: assert property (p_rst) else $error("bad state after reset");
  a_unav: assert property (p_unav) else $error("unavailable too early");
  a_unav_tick: assert property (p_unav_tick) else $error("unavailable off tick");
endmodule
`default_nettype wire

/* test/slpm_far_end.sv */
// Far-end line terminating equipment model: error reports and line defects
`timescale 1ns/10ps
`default_nettype none
module slpm_far_end #(
  parameter int STS_N = 48
) (
  input  wire logic       i_frame,
  input  wire logic [8:0] i_rei_req,
  input  wire logic       i_rdi,
  input  wire logic       i_rfi,
  output logic      [7:0] o_rei_errs,
  output logic            o_rdi_defect,
  output logic            o_rfi_fail
);
  localparam int lim = (STS_N >= 48) ? 255 : 8 * STS_N;
  logic [7:0] rei;
  assign rei = (i_rei_req > 9'(lim)) ? 8'(lim) : i_rei_req[7:0];
  // No report outside a frame, so no held value either
  assign o_rei_errs = i_frame ? rei : ~rei;
  assign o_rdi_defect = i_rdi;
  assign o_rfi_fail = i_rfi;
endmodule
`default_nettype wire

/* test/tb_slpm_counters.sv */
// Self-checking bench for the performance counter block
`timescale 1ns/10ps
`default_nettype none
`include "slpm_consts.vh"
module tb_slpm_counters;
  logic             clk, srst, frame, sec, per, sef, los, ais, rdi, aisf, lowf, rfi;
  logic             awv, wv, bry, arv, rry, rdi_w, rfi_w;
  logic [3:0]       b1;
  logic [9:0]       b2;
  logic [8:0]       rq;
  logic [7:0]       rei, awa, ara;
  logic [31:0]      wd;
  wire logic        awrdy, wrdy, bv, arr, rv, unn, unf, irq;
  wire logic [1:0]  br, rr;
  wire logic [31:0] rdat;
  logic [31:0]      e [0:13];
  logic [31:0]      p [0:13];
  int               n_errors, tests_run;
  localparam logic [1:0] ok = `SLPM_RESP_OKAY;
  localparam logic [1:0] er = `SLPM_RESP_SLVERR;
  slpm_far_end #(.STS_N(48)) far (.i_frame(frame), .i_rei_req(rq), .i_rdi(rdi), .i_rfi(rfi),
    .o_rei_errs(rei), .o_rdi_defect(rdi_w), .o_rfi_fail(rfi_w));
  slpm_counters #(.STS_N(48)) DUT (.I_CLOCK(clk), .I_SRST(srst), .I_FRAME(frame),
    .I_B1_ERRS(b1), .I_B2_ERRS(b2), .I_REI_ERRS(rei), .I_SEF_DEFECT(sef),
    .I_LOS_DEFECT(los), .I_AIS_DEFECT(ais), .I_RDI_DEFECT(rdi_w), .I_AIS_FAIL(aisf),
    .I_LOWER_FAIL(lowf), .I_RFI_FAIL(rfi_w), .I_SEC_TICK(sec), .I_PERIOD_TICK(per),
    .I_AWADDR(awa), .I_AWVALID(awv), .O_AWREADY(awrdy), .I_WDATA(wd), .I_WSTRB(4'hf),
    .I_WVALID(wv), .O_WREADY(wrdy), .O_BRESP(br), .O_BVALID(bv), .I_BREADY(bry),
    .I_ARADDR(ara), .I_ARVALID(arv), .O_ARREADY(arr), .O_RDATA(rdat), .O_RRESP(rr),
    .O_RVALID(rv), .I_RREADY(rry), .O_UNAVAIL_NEAR(unn), .O_UNAVAIL_FAR(unf), .O_IRQ(irq));
  task automatic chk(input [31:0] g, input [31:0] x);
    tests_run++;
    if (g !== x) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic wr(input [7:0] a, input [31:0] d, input [1:0] xr);
    logic pa, pw;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    bry <= 1'h1;
    pa = 1'h1;
    pw = 1'h1;
    while (pa || pw) begin
      @(posedge clk);
      if (awrdy) pa = 1'h0;
      if (wrdy) pw = 1'h0;
      awv <= pa;
      wv <= pw;
    end
    do @(posedge clk); while (!bv);
    bry <= 1'h0;
    chk(32'(br), 32'(xr));
  endtask
  task automatic rd(input [7:0] a, input [31:0] xd, input [1:0] xr);
    @(posedge clk);
    ara <= a;
    arv <= 1'h1;
    rry <= 1'h1;
    do @(posedge clk); while (!arr);
    arv <= 1'h0;
    do @(posedge clk); while (!rv);
    rry <= 1'h0;
    chk(32'(rr), 32'(xr));
    if (xr == ok) chk(rdat, xd);
  endtask
  task automatic all_cnt(input bit prev);
    for (int i = 0; i < `SLPM_NUM_COUNTERS; i++)
      rd((prev ? 8'h80 : 8'h40) + 8'(4 * i), prev ? p[i] : e[i], ok);
  endtask
  task automatic frm(input [3:0] x1, input [9:0] x2, input [8:0] xq);
    @(posedge clk);
    frame <= 1'h1;
    b1 <= x1;
    b2 <= x2;
    rq <= xq;
    @(posedge clk);
    frame <= 1'h0;
  endtask
  task automatic tick(input bit pd);
    @(posedge clk);
    sec <= 1'h1;
    per <= pd;
    @(posedge clk);
    sec <= 1'h0;
    per <= 1'h0;
  endtask
  task automatic t_regs;
    for (int i = 0; i < 3; i++)
      rd(8'(4 * i), 32'h100, ok);
    rd(`SLPM_ADDR_INT_ENABLE, 32'h0, ok);
    rd(8'hfc, 32'h0, er);
    wr(`SLPM_ADDR_INT_STATUS, 32'h1, er);
    wr(`SLPM_ADDR_K_SECTION, 32'h4, ok);
    wr(`SLPM_ADDR_K_LINE, 32'ha, ok);
    wr(`SLPM_ADDR_K_FAR, 32'h12c, ok);
    rd(`SLPM_ADDR_K_FAR, 32'h12c, ok);
  endtask
  task automatic t_layers;
    frm(4'h3, 10'h0, 9'h0);
    frm(4'h8, 10'h180, 9'h1ff);
    frm(4'h0, 10'h0, 9'h02d);
    tick(1'h0);
    sef <= 1'h1;
    tick(1'h0);
    sef <= 1'h0;
    los <= 1'h1;
    ais <= 1'h1;
    rdi <= 1'h1;
    tick(1'h0);
    {los, ais, rdi} <= 3'h0;
    frm(4'h4, 10'h009, 9'h0ff);
    frm(4'h0, 10'h0, 9'h02c);
    tick(1'h0);
    frm(4'h3, 10'h00a, 9'h0);
    tick(1'h0);
    // Thresholds sit exactly at K on one side of each boundary
    e = '{18, 5, 4, 1, 403, 4, 3, 0, 0, 599, 3, 2, 0, 0};
    all_cnt(1'h0);
  endtask
  task automatic t_unav;
    wr(`SLPM_ADDR_INT_ENABLE, 32'h4, ok);
    // Clean second breaks the severe run left by the layer test
    tick(1'h0);
    ais <= 1'h1;
    rdi <= 1'h1;
    repeat (9) tick(1'h0);
    repeat (4) @(posedge clk);
    chk(32'({unf, unn}), 32'h0);
    tick(1'h0);
    ais <= 1'h0;
    rdi <= 1'h0;
    repeat (4) @(posedge clk);
    chk(32'({unf, unn, irq}), 32'h7);
    rd(`SLPM_ADDR_INT_STATUS, 32'hd, ok);
    wr(`SLPM_ADDR_INT_CLEAR, 32'h4, ok);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    repeat (9) tick(1'h0);
    repeat (4) @(posedge clk);
    chk(32'({unf, unn}), 32'h3);
    rd(`SLPM_ADDR_STATE, 32'h3, ok);
    tick(1'h0);
    repeat (4) @(posedge clk);
    chk(32'({unf, unn}), 32'h0);
    wr(`SLPM_ADDR_INT_ENABLE, 32'h0, ok);
    e = '{18, 5, 4, 1, 403, 14, 13, 20, 0, 599, 13, 12, 20, 0};
    all_cnt(1'h0);
  endtask
  task automatic t_fail;
    tick(1'h1);
    p = e;
    all_cnt(1'h1);
    aisf <= 1'h1;
    rfi <= 1'h1;
    repeat (3) @(posedge clk);
    lowf <= 1'h1;
    tick(1'h1);
    {aisf, rfi, lowf} <= 3'h0;
    repeat (3) @(posedge clk);
    lowf <= 1'h1;
    repeat (3) @(posedge clk);
    p = '{8: 1, 13: 1, default: 0};
    e = '{8: 1, default: 0};
    all_cnt(1'h1);
    all_cnt(1'h0);
    rd(`SLPM_ADDR_INT_STATUS, 32'h3b, ok);
  endtask
  task end_of_test;
    if (n_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_of_test;
  end
  initial begin
    {frame, sec, per, sef, los, ais, rdi, aisf, lowf, rfi, awv, wv, bry, arv, rry} = '0;
    {b1, b2, rq, awa, ara, wd} = '0;
    srst = 1'h1;
    repeat (12) @(posedge clk);
    srst <= 1'h0;
    t_regs;
    t_layers;
    t_unav;
    t_fail;
    end_of_test;
  end
endmodule
bind slpm_counters slpm_counters_chk chk_i (.I_CLOCK(I_CLOCK), .I_SRST(I_SRST),
  .I_SEC_TICK(I_SEC_TICK), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY),
  .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY),
  .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY),
  .O_UNAVAIL_NEAR(O_UNAVAIL_NEAR), .O_UNAVAIL_FAR(O_UNAVAIL_FAR), .O_IRQ(O_IRQ));
`default_nettype wire
